// File: include/sscp_pkg.sv
/*
 Constants, codes and types shared by the serial command translator.
 Assumes a single 125 MHz clock domain and a synchronous active-low reset.
*/
package sscp_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BAUD_HZ = 9600;
    // Rounded down: 13020 cycles, about 0.006 percent fast
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int unsigned FRAME_BITS = 10;

    // ------------------------------------------------------------------
    // Register map and bus answers
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_FCNT = 8'h0c;
    localparam int unsigned MODE_BIT = 0;
    localparam int unsigned STAT_BUSY = 4;
    localparam int unsigned STAT_MODE = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Selector positions
    // ------------------------------------------------------------------
    localparam logic [3:0] POS_LINE = 4'h5;
    localparam logic [3:0] POS_GATE = 4'h6;
    localparam logic [3:0] POS_IMAGE = 4'h7;
    localparam logic [3:0] POS_HAND = 4'h8;

    // ------------------------------------------------------------------
    // Characters
    // ------------------------------------------------------------------
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_DC2 = 8'h12;
    localparam logic [7:0] CH_DC4 = 8'h14;
    localparam logic [7:0] CH_SYN = 8'h16;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_2 = 8'h32;
    localparam logic [7:0] CH_3 = 8'h33;
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_H = 8'h48;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_U = 8'h55;
    localparam logic [7:0] CH_V = 8'h56;
    localparam logic [7:0] CH_I = 8'h69;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_STX = 3'b001,
        FR_PAY = 3'b010,
        FR_CR = 3'b011,
        FR_LF = 3'b100
    } sscp_frame_t;

    typedef enum logic [0:0] {
        UT_IDLE = 1'b0,
        UT_SEND = 1'b1
    } sscp_uart_t;
endpackage : sscp_pkg

// File: hw/sscp_uart_tx.sv
/*
 Asynchronous serial transmitter, eight data bits, no parity, one stop bit.
 Assumes the caller holds tx_valid and tx_data until tx_ready is seen.
*/
`timescale 1ns/1ns
module sscp_uart_tx #(
    parameter int unsigned BIT_CYCLES = sscp_pkg::BIT_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic txd
);
    localparam int unsigned CNT_W = $clog2(BIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BIT_CYCLES - 1);
    localparam logic [3:0] LAST_BIT = 4'(sscp_pkg::FRAME_BITS - 1);

    sscp_pkg::sscp_uart_t st_r, st_nxt;
    logic [9:0] sh_r, sh_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] nb_r, nb_nxt;
    logic txd_r, txd_nxt;

    assign tx_ready = (st_r == sscp_pkg::UT_IDLE);
    assign txd = txd_r;

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        nb_nxt = nb_r;
        txd_nxt = txd_r;
        case (st_r)
            sscp_pkg::UT_IDLE: begin
                txd_nxt = 1'b1;
                if (tx_valid) begin
                    sh_nxt = {1'b1, tx_data, 1'b0};
                    cnt_nxt = '0;
                    nb_nxt = 4'h0;
                    txd_nxt = 1'b0;
                    st_nxt = sscp_pkg::UT_SEND;
                end
            end
            sscp_pkg::UT_SEND: begin
                if (cnt_r == CNT_LAST) begin
                    cnt_nxt = '0;
                    if (nb_r == LAST_BIT) begin
                        txd_nxt = 1'b1;
                        st_nxt = sscp_pkg::UT_IDLE;
                    end else begin
                        nb_nxt = nb_r + 4'h1;
                        sh_nxt = {1'b1, sh_r[9:1]};
                        txd_nxt = sh_r[1];
                    end
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            default: begin
                st_nxt = sscp_pkg::UT_IDLE;
                txd_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= sscp_pkg::UT_IDLE;
            sh_r <= 10'h3ff;
            cnt_r <= '0;
            nb_r <= 4'h0;
            txd_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            nb_r <= nb_nxt;
            txd_r <= txd_nxt;
        end
    end
endmodule : sscp_uart_tx

// File: hw/sscp_top.sv
/*
 Serial command translator: control bits written over AXI4-Lite become
 framed ASCII commands on the reader's serial line, per selector profile.
 Assumes the switch input is synchronous and steady between writes.
*/
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module sscp_top #(
    parameter int unsigned BIT_CYCLES = sscp_pkg::BIT_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [3:0] profile_selector_switch,
    output logic txd
);
    // ------------------------------------------------------------------
    // Command table
    // ------------------------------------------------------------------
    // Returns {length, bytes}; first byte in the top lane, length 0 = none
    function automatic logic [34:0] cmd_lookup(input logic [3:0] prof, input logic [3:0] idx,
                                               input logic lvl);
        logic [34:0] r;
        r = '0;
        case (prof)
            sscp_pkg::POS_LINE: begin
                case (idx)
                    4'h0: if (lvl) r = {3'h1, sscp_pkg::CH_V, 24'h0};
                    4'h1: r = {3'h1, lvl ? sscp_pkg::CH_PLUS : sscp_pkg::CH_MINUS,
                               24'h0};
                    4'h2: if (lvl) r = {3'h2, sscp_pkg::CH_1, sscp_pkg::CH_1, 16'h0};
                    4'h3: if (lvl) r = {3'h2, sscp_pkg::CH_1, sscp_pkg::CH_2, 16'h0};
                    4'h4: if (lvl) r = {3'h2, sscp_pkg::CH_1, sscp_pkg::CH_3, 16'h0};
                    4'he: if (lvl) r = {3'h4, sscp_pkg::CH_P, sscp_pkg::CH_C,
                                        sscp_pkg::CH_2, sscp_pkg::CH_0};
                    4'hf: if (lvl) r = {3'h1, sscp_pkg::CH_H, 24'h0};
                    default: r = '0;
                endcase
            end
            sscp_pkg::POS_GATE: begin
                case (idx)
                    4'h0: if (lvl) r = {3'h1, sscp_pkg::CH_I, 24'h0};
                    4'h1: r = {3'h1, lvl ? sscp_pkg::CH_DC2 : sscp_pkg::CH_DC4,
                               24'h0};
                    4'h2: if (lvl) r = {3'h3, sscp_pkg::CH_SYN, sscp_pkg::CH_T,
                                        sscp_pkg::CH_CR, 8'h00};
                    4'h3: if (lvl) r = {3'h3, sscp_pkg::CH_SYN, sscp_pkg::CH_U,
                                        sscp_pkg::CH_CR, 8'h00};
                    default: r = '0;
                endcase
            end
            sscp_pkg::POS_IMAGE: begin
                case (idx)
                    4'h0: if (lvl) r = {3'h1, sscp_pkg::CH_V, 24'h0};
                    4'h1: if (lvl) r = {3'h1, sscp_pkg::CH_PLUS, 24'h0};
                    default: r = '0;
                endcase
            end
            // Hand-held and foreign positions map nothing
            default: r = '0;
        endcase
        return r;
    endfunction : cmd_lookup

    // ------------------------------------------------------------------
    // Bus and register state
    // ------------------------------------------------------------------
    logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, mode_r, mode_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt, do_write, ctrl_write, frame_done;
    logic [7:0] waddr_r, waddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, fcnt_r, fcnt_nxt;
    logic [3:0] wstrb_r, wstrb_nxt, prof_r;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;

    // ------------------------------------------------------------------
    // Command and framer state
    // ------------------------------------------------------------------
    logic [15:0] pend_r, pend_nxt, lvl_r, lvl_nxt, event_w, served;
    sscp_pkg::sscp_frame_t fr_r, fr_nxt;
    logic [31:0] pay_r, pay_nxt;
    logic [2:0] len_r, len_nxt, idx_r, idx_nxt;
    logic tx_valid, tx_ready, pick_any;
    logic [7:0] tx_data;
    logic [34:0] pick;
    logic [3:0] pick_idx;

    assign s_axil_awready = awready_r;
    assign s_axil_wready = wready_r;
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;
    assign s_axil_arready = arready_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rdata = rdata_r;
    assign s_axil_rresp = rresp_r;

    assign do_write = aw_full_r && w_full_r && !bvalid_r;
    assign ctrl_write = do_write && (waddr_r == sscp_pkg::OFS_CTRL);

    // Transition events, only in command mode and never for the hand-held
    generate
        for (genvar g = 0; g < 16; g++) begin : g_evt
            logic [34:0] ent;
            assign ent = cmd_lookup(prof_r, 4'(g), ctrl_nxt[g]);
            assign event_w[g] = ctrl_write && mode_r
                && (prof_r != sscp_pkg::POS_HAND)
                && (ctrl_nxt[g] != ctrl_r[g])
                && (ent[34:32] != 3'h0);
        end
    endgenerate

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !s_axil_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axil_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        mode_nxt = mode_r;
        ctrl_nxt = ctrl_r;
        fcnt_nxt = frame_done ? fcnt_r + 32'h1 : fcnt_r;
        if (s_axil_awvalid && awready_r) begin
            aw_full_nxt = 1'b1;
            waddr_nxt = s_axil_awaddr;
        end
        if (s_axil_wvalid && wready_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axil_wdata;
            wstrb_nxt = s_axil_wstrb;
        end
        if (do_write) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = sscp_pkg::RESP_OKAY;
            case (waddr_r)
                sscp_pkg::OFS_MODE: if (wstrb_r[0]) mode_nxt = wdata_r[sscp_pkg::MODE_BIT];
                sscp_pkg::OFS_CTRL: begin
                    if (wstrb_r[0]) ctrl_nxt[7:0] = wdata_r[7:0];
                    if (wstrb_r[1]) ctrl_nxt[15:8] = wdata_r[15:8];
                end
                sscp_pkg::OFS_STAT, sscp_pkg::OFS_FCNT: ; // Read-only, writes ignored
                default: bresp_nxt = sscp_pkg::RESP_SLVERR;
            endcase
        end
        // One write in flight: hold both channels until the answer is taken
        awready_nxt = !aw_full_nxt && !bvalid_nxt;
        wready_nxt = !w_full_nxt && !bvalid_nxt;
        if (s_axil_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = sscp_pkg::RESP_OKAY;
            case (s_axil_araddr)
                sscp_pkg::OFS_MODE: rdata_nxt = {31'h0, mode_r};
                sscp_pkg::OFS_CTRL: rdata_nxt = {16'h0, ctrl_r};
                sscp_pkg::OFS_STAT: rdata_nxt = {pend_r, 10'h0, mode_r, tx_valid, prof_r};
                sscp_pkg::OFS_FCNT: rdata_nxt = fcnt_r;
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = sscp_pkg::RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= sscp_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= sscp_pkg::RESP_OKAY;
            mode_r <= 1'b0;
            ctrl_r <= sscp_pkg::CTRL_RESET;
            prof_r <= 4'h0;
            fcnt_r <= 32'h0;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            mode_r <= mode_nxt;
            ctrl_r <= ctrl_nxt;
            prof_r <= profile_selector_switch;
            fcnt_r <= fcnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Command scheduler and framer
    // ------------------------------------------------------------------
    // Lowest pending bit goes first; a bit that moves twice before its
    // turn sends only the string for the latest level that maps one
    always_comb begin
        pick_any = 1'b0;
        pick_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (pend_r[i]) begin
                pick_any = 1'b1;
                pick_idx = 4'(i);
            end
        end
        pick = cmd_lookup(prof_r, pick_idx, lvl_r[pick_idx]);
    end

    assign tx_valid = (fr_r != sscp_pkg::FR_IDLE);
    assign frame_done = (fr_r == sscp_pkg::FR_LF) && tx_ready;

    always_comb begin
        fr_nxt = fr_r;
        pay_nxt = pay_r;
        len_nxt = len_r;
        idx_nxt = idx_r;
        served = 16'h0;
        tx_data = sscp_pkg::CH_LF;
        case (fr_r)
            sscp_pkg::FR_IDLE: begin
                if (pick_any) begin
                    served[pick_idx] = 1'b1;
                    pay_nxt = pick[31:0];
                    len_nxt = pick[34:32];
                    idx_nxt = 3'h0;
                    if (pick[34:32] == 3'h0) fr_nxt = sscp_pkg::FR_IDLE; // Moved away: drop
                    else if (prof_r == sscp_pkg::POS_HAND) fr_nxt = sscp_pkg::FR_PAY;
                    else fr_nxt = sscp_pkg::FR_STX;
                end
            end
            sscp_pkg::FR_STX: begin
                tx_data = sscp_pkg::CH_STX;
                if (tx_ready) fr_nxt = sscp_pkg::FR_PAY;
            end
            sscp_pkg::FR_PAY: begin
                tx_data = pay_r[31:24];
                if (tx_ready) begin
                    pay_nxt = {pay_r[23:0], 8'h00};
                    idx_nxt = idx_r + 3'h1;
                    if (idx_r + 3'h1 == len_r) fr_nxt = sscp_pkg::FR_CR;
                end
            end
            sscp_pkg::FR_CR: begin
                tx_data = sscp_pkg::CH_CR;
                if (tx_ready) fr_nxt = sscp_pkg::FR_LF;
            end
            sscp_pkg::FR_LF: begin
                tx_data = sscp_pkg::CH_LF;
                if (tx_ready) fr_nxt = sscp_pkg::FR_IDLE;
            end
            default: fr_nxt = sscp_pkg::FR_IDLE;
        endcase
        // A new edge in the cycle its bit is served stays pending
        pend_nxt = (pend_r & ~served) | event_w;
        lvl_nxt = (lvl_r & ~event_w) | (ctrl_nxt & event_w);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fr_r <= sscp_pkg::FR_IDLE;
            pay_r <= 32'h0;
            len_r <= 3'h0;
            idx_r <= 3'h0;
            pend_r <= 16'h0;
            lvl_r <= 16'h0;
        end else begin
            fr_r <= fr_nxt;
            pay_r <= pay_nxt;
            len_r <= len_nxt;
            idx_r <= idx_nxt;
            pend_r <= pend_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial line
    // ------------------------------------------------------------------
    // No flow-control pins: the line is driven blind, nothing is awaited
    sscp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .txd(txd)
    );
endmodule : sscp_top

// File: tb/sscp_top_asserts.sv
/* Port checker for sscp_top: bus handshakes and serial character timing.
 Assumes one clock domain and that it is bound to every sscp_top. */
`timescale 1ns/1ns
module sscp_top_asserts #(
    parameter int unsigned BIT_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic txd
);
    // ----
    // Run length of the line level
    // ----
    logic txd_q_r;
    logic [31:0] run_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd_q_r <= 1'b1;
            run_r <= 32'h0;
        end else begin
            txd_q_r <= txd;
            run_r <= (txd == txd_q_r) ? run_r + 32'h1 : 32'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_txd_idle_reset: assert property (disable iff (1'b0) !aresetn |=> txd)
        else $error("txd not idle after reset");
    a_low_run_whole: assert property (txd && !txd_q_r |-> (run_r % BIT_CYCLES) == 0)
        else $error("low level not whole bit times");
    a_low_run_max: assert property (!txd_q_r |-> run_r <= 9 * BIT_CYCLES)
        else $error("stop bit missing");
    a_write_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
        && s_axil_wready |-> ##2 s_axil_bvalid) else $error("write answer late");
    a_aw_refuse: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
        else $error("second write taken");
    a_bvalid_once: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write answer repeated");
    a_read_answer: assert property (s_axil_arvalid && s_axil_arready
        |=> s_axil_rvalid && !s_axil_arready) else $error("read answer wrong");
    a_rvalid_once: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
        else $error("read answer repeated");
    a_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready |=> $stable(s_axil_rdata))
        else $error("read data moved");
endmodule : sscp_top_asserts
bind sscp_top sscp_top_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_asserts (.aclk(aclk),
    .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata), .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready), .txd(txd));

// File: tb/sscp_reader_model.sv
/* Reader-side receiver: decodes 8N1 characters from txd.
 Assumes txd idles high; sends nothing back, as the link has no handshake. */
`timescale 1ns/1ns
module sscp_reader_model #(
    parameter int unsigned BIT_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic txd,
    output logic [7:0] rx_byte,
    output logic rx_stop,
    output logic rx_stb
);
    // ----
    // Mid-bit sampling, no acknowledge ever returned
    // ----
    initial begin
        rx_byte = 8'h00;
        rx_stop = 1'b1;
        rx_stb = 1'b0;
        forever begin
            @(negedge txd);
            if (aresetn === 1'b1) begin
                repeat (BIT_CYCLES / 2) @(posedge aclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(posedge aclk);
                    rx_byte[i] <= txd;
                end
                repeat (BIT_CYCLES) @(posedge aclk);
                rx_stop <= txd;
                rx_stb <= 1'b1;
                @(posedge aclk);
                rx_stb <= 1'b0;
            end
        end
    end
endmodule : sscp_reader_model

// File: tb/sscp_top_tb.sv
/* Self-checking bench for sscp_top: AXI4-Lite master, reader model, byte queue.
 Assumes a short bit time so every profile fits in one run. */
`timescale 1ns/1ns
module sscp_top_tb;
    localparam int unsigned BITC = 8;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, txd, rx_stop, rx_stb;
    logic [7:0] awaddr, araddr, rx_byte;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, sel;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int num_checks = 0;
    int frames = 0;
    sscp_top #(.BIT_CYCLES(BITC)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .profile_selector_switch(sel), .txd(txd));
    sscp_reader_model #(.BIT_CYCLES(BITC)) u_reader (.aclk(aclk), .aresetn(aresetn),
        .txd(txd), .rx_byte(rx_byte), .rx_stop(rx_stop), .rx_stb(rx_stb));
    // ----
    // Checking and bus tasks
    // ----
    task automatic mismatch(input string m);
        fail_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask : mismatch
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) mismatch(m);
    endtask : check_word
    task automatic end_of_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        {aw_done, w_done} = 2'b00;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) aw_done = 1'b1;
            if (wready === 1'b1) w_done = 1'b1;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check_word({30'h0, bresp}, 32'h0, "write refused");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // Idle, then eleven bit times, one character and one bit, for the last byte
    task automatic drain;
        do axi_rd(sscp_pkg::OFS_STAT, rd, rs);
        while (rd[31:16] !== 16'h0 || rd[sscp_pkg::STAT_BUSY] !== 1'b0);
        repeat (11 * BITC) @(posedge aclk);
    endtask : drain
    function automatic string cmd_str(input int p, input int b, input bit up);
        if (!up) return (b != 1) ? "" : (p == 5) ? "-" : (p == 6) ? $sformatf("%c", 8'h14) : "";
        case (p)
            5: return (b == 0) ? "V" : (b == 1) ? "+" : (b == 2) ? "11" : (b == 3) ? "12" :
                (b == 4) ? "13" : (b == 14) ? "PC20" : (b == 15) ? "H" : "";
            6: return (b == 0) ? "i" : (b == 1) ? $sformatf("%c", 8'h12) :
                (b == 2) ? $sformatf("%cT%c", 8'h16, 8'h0d) :
                (b == 3) ? $sformatf("%cU%c", 8'h16, 8'h0d) : "";
            7: return (b == 0) ? "V" : (b == 1) ? "+" : "";
            default: return "";
        endcase
    endfunction : cmd_str
    task automatic expect_frame(input string s);
        if (s.len() != 0) begin
            frames++;
            exp_q.push_back(sscp_pkg::CH_STX);
            for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
            exp_q.push_back(sscp_pkg::CH_CR);
            exp_q.push_back(sscp_pkg::CH_LF);
        end
    endtask : expect_frame
    // ----
    // Clock, byte monitor, watchdog, main sequence
    // ----
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_stb === 1'b1) begin
            if (exp_q.size() == 0) mismatch("unexpected byte");
            else check_word({24'h0, rx_byte}, {24'h0, exp_q.pop_front()}, "byte");
            check_word({31'h0, rx_stop}, 32'h1, "stop bit");
        end
    end
    initial begin
        repeat (60000) @(posedge aclk);
        mismatch("timeout");
        end_of_test;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb, sel} = {16'h0, 32'h0, 4'hf, 4'h5};
        void'($urandom(60198));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(sscp_pkg::OFS_MODE, rd, rs);
        check_word(rd, 32'h0, "mode reset");
        axi_rd(8'h10, rd, rs);
        check_word({rd[29:0], rs}, {30'h0, sscp_pkg::RESP_SLVERR}, "unmapped read");
        axi_wr(sscp_pkg::OFS_CTRL, 32'h3);
        axi_wr(sscp_pkg::OFS_CTRL, 32'h0);
        drain;
        axi_wr(sscp_pkg::OFS_MODE, 32'h1);
        repeat (4) begin
            rd = $urandom % 11;
            sel <= (rd < 5) ? rd[3:0] : rd[3:0] + 4'h4;
            axi_wr(sscp_pkg::OFS_CTRL, 32'hffff);
            axi_wr(sscp_pkg::OFS_CTRL, 32'h0);
            drain;
        end
        for (int p = 5; p <= 8; p++) begin
            sel <= p[3:0];
            for (int b = 0; b < 16; b++) begin
                axi_wr(sscp_pkg::OFS_CTRL, 32'h1 << b);
                expect_frame(cmd_str(p, b, 1'b1));
                drain;
                axi_wr(sscp_pkg::OFS_CTRL, 32'h0);
                expect_frame(cmd_str(p, b, 1'b0));
                drain;
            end
        end
        sel <= 4'h5;
        axi_wr(sscp_pkg::OFS_CTRL, 32'hffff);
        for (int b = 0; b < 16; b++) expect_frame(cmd_str(5, b, 1'b1));
        drain;
        axi_rd(sscp_pkg::OFS_FCNT, rd, rs);
        check_word(rd, frames, "frame count");
        check_word(exp_q.size(), 32'h0, "bytes missing");
        end_of_test;
    end
endmodule : sscp_top_tb
